// File: lsru_top.sv
// logic, shift and rotate unit with a wishbone register port
`include "lsru_map.svh"
`default_nettype none
// Behaviour
// - logicals with flags clear overflow and carry
// - aux carry undefined after logicals
// - sign follows result top bit
// - zero set when result all zero
// - parity set on even one count
// - invert complements operand, flags untouched
// - and keeps ones common to both
// - or keeps ones of either
// - xor keeps differing bits
// - test posts and flags, no writeback
// - count is one or count register
// - shift carry is last bit out
// - single shift overflow is msb change
// - both left shifts identical, zero fill
// - logical right shift fills zeros
// - arithmetic right shift copies sign bit
// - arithmetic right rounds toward minus infinity
// - rotates change only carry and overflow
// - rotate carry is last bit out
// - single rotate overflow is msb change
// - plain rotates circulate bits without loss
// - carry rotates include carry as extra bit
module lsru_top (
   input  wire logic        mclk,           // 20 MHz clock
   input  wire logic        rst,            // asynchronous reset, active high
   input  wire logic        wb_cyc_i,       // wishbone cycle
   input  wire logic        wb_stb_i,       // wishbone strobe
   input  wire logic        wb_we_i,        // wishbone write enable
   input  wire logic [7:0]  wb_adr_i,       // wishbone byte address
   input  wire logic [3:0]  wb_sel_i,       // wishbone byte lanes
   input  wire logic [31:0] wb_dat_i,       // wishbone write data
   output logic      [31:0] wb_dat_o,       // wishbone read data
   output logic             wb_ack_o,       // wishbone acknowledge
   output logic      [15:0] result,         // last written-back result
   output logic             carry_flag,     // carry flag
   output logic             overflow_flag,  // overflow flag
   output logic             aux_carry_flag, // auxiliary carry flag
   output logic             sign_flag,      // sign flag
   output logic             zero_flag,      // zero flag
   output logic             parity_flag,    // parity flag
   output logic             busy            // multi-cycle shift in progress
);
   logic [15:0]           opa;
   logic [15:0]           opb;
   logic [7:0]            shift_count_register;
   lsru_pkg::lsru_op_t    op;
   logic                  word;
   logic                  use_cnt;
   lsru_pkg::lsru_state_t state;
   logic [7:0]            remaining;
   logic [15:0]           work;
   logic                  work_c;
   logic                  orig_msb;
   logic [15:0]           next_work;
   logic                  next_c;

   logic                  bus_req;
   logic                  bus_wr;
   logic                  idle;
   logic                  wr_ctrl;
   lsru_pkg::lsru_op_t    new_op;
   logic                  new_word;
   logic [7:0]            new_cnt;
   logic [15:0]           new_mask;
   logic [15:0]           lg_val;
   logic                  new_logic;
   logic                  new_shift;
   logic                  run_rot;
   logic                  last_step;
   logic [5:0]            flags_word;

   function automatic logic top_bit(input logic [15:0] v, input logic w);
      return w ? v[15] : v[7];
   endfunction

   assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr    = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o; // lands at the acked edge
   assign idle      = (state == lsru_pkg::lsru_idle);
   assign wr_ctrl   = bus_wr & wb_sel_i[0] & idle & (wb_adr_i == `LSRU_ADR_CTRL);
   assign new_op    = lsru_pkg::lsru_op_t'(wb_dat_i[3:0]);
   assign new_word  = wb_dat_i[`LSRU_CTL_WORD];
   assign new_cnt   = wb_dat_i[`LSRU_CTL_USECNT] ? shift_count_register
                                                 : `LSRU_COUNT_ONE;
   assign new_mask  = new_word ? `LSRU_MASK_WORD : `LSRU_MASK_BYTE;
   assign last_step = (state == lsru_pkg::lsru_run) && (remaining == `LSRU_COUNT_ONE);
   assign run_rot   = (op == lsru_pkg::lsru_op_rot_l) || (op == lsru_pkg::lsru_op_rot_r) ||
                      (op == lsru_pkg::lsru_op_rotc_l) || (op == lsru_pkg::lsru_op_rotc_r);

   always_comb begin
      new_logic = 1'b0;
      new_shift = 1'b0;
      case (new_op)
         lsru_pkg::lsru_op_and, lsru_pkg::lsru_op_test: begin
            lg_val    = opa & opb & new_mask;
            new_logic = 1'b1;
         end
         lsru_pkg::lsru_op_or: begin
            lg_val    = (opa | opb) & new_mask;
            new_logic = 1'b1;
         end
         lsru_pkg::lsru_op_xor: begin
            lg_val    = (opa ^ opb) & new_mask;
            new_logic = 1'b1;
         end
         lsru_pkg::lsru_op_not: begin
            lg_val = ~opa & new_mask;
         end
         lsru_pkg::lsru_op_shift_l, lsru_pkg::lsru_op_shift_la, lsru_pkg::lsru_op_shift_r,
         lsru_pkg::lsru_op_shift_ra, lsru_pkg::lsru_op_rot_l, lsru_pkg::lsru_op_rot_r,
         lsru_pkg::lsru_op_rotc_l, lsru_pkg::lsru_op_rotc_r: begin
            lg_val    = opa & new_mask;
            new_shift = 1'b1;
         end
         default: begin
            lg_val = opa & new_mask;
         end
      endcase
   end

   lsru_step u_step (
      .value      (work),
      .carry_in   (work_c),
      .op         (op),
      .word       (word),
      .next_value (next_work),
      .carry_out  (next_c)
   );

   // wishbone answer one cycle after the request, unmapped reads give zero
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   always_comb begin
      flags_word                   = 6'h00;
      flags_word[`LSRU_FLG_CARRY]  = carry_flag;
      flags_word[`LSRU_FLG_PARITY] = parity_flag;
      flags_word[`LSRU_FLG_AUX]    = aux_carry_flag;
      flags_word[`LSRU_FLG_ZERO]   = zero_flag;
      flags_word[`LSRU_FLG_SIGN]   = sign_flag;
      flags_word[`LSRU_FLG_OVF]    = overflow_flag;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (bus_req & ~wb_we_i) begin
         case (wb_adr_i)
            `LSRU_ADR_OPA:    wb_dat_o <= {16'h0000, opa};
            `LSRU_ADR_OPB:    wb_dat_o <= {16'h0000, opb};
            `LSRU_ADR_COUNT:  wb_dat_o <= {24'h00_0000, shift_count_register};
            `LSRU_ADR_FLAGS:  wb_dat_o <= {26'h000_0000, flags_word};
            `LSRU_ADR_CTRL:   wb_dat_o <= {23'h00_0000, busy, 2'h0, use_cnt, word, op};
            `LSRU_ADR_RESULT: wb_dat_o <= {16'h0000, result};
            default:          wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // operands and count are frozen while a shift runs
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         opa                  <= 16'h0000;
         opb                  <= 16'h0000;
         shift_count_register <= 8'h00;
      end else if (bus_wr & idle) begin
         if (wb_adr_i == `LSRU_ADR_OPA && wb_sel_i[0]) opa[7:0] <= wb_dat_i[7:0];
         if (wb_adr_i == `LSRU_ADR_OPA && wb_sel_i[1]) opa[15:8] <= wb_dat_i[15:8];
         if (wb_adr_i == `LSRU_ADR_OPB && wb_sel_i[0]) opb[7:0] <= wb_dat_i[7:0];
         if (wb_adr_i == `LSRU_ADR_OPB && wb_sel_i[1]) opb[15:8] <= wb_dat_i[15:8];
         if (wb_adr_i == `LSRU_ADR_COUNT && wb_sel_i[0]) begin
            shift_count_register <= wb_dat_i[7:0];
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         op      <= lsru_pkg::lsru_op_not;
         word    <= 1'b0;
         use_cnt <= 1'b0;
      end else if (wr_ctrl) begin
         op      <= new_op;
         word    <= new_word;
         use_cnt <= wb_dat_i[`LSRU_CTL_USECNT];
      end
   end

   // shift engine: one position per cycle, so the carry is the last bit out
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state     <= lsru_pkg::lsru_idle;
         busy      <= 1'b0;
         remaining <= 8'h00;
         work      <= 16'h0000;
         work_c    <= 1'b0;
         orig_msb  <= 1'b0;
      end else begin
         case (state)
            lsru_pkg::lsru_idle: begin
               if (wr_ctrl && new_shift && new_cnt != 8'h00) begin
                  state     <= lsru_pkg::lsru_run;
                  busy      <= 1'b1;
                  remaining <= new_cnt;
                  work      <= lg_val;
                  work_c    <= carry_flag;
                  orig_msb  <= top_bit(lg_val, new_word);
               end
            end
            lsru_pkg::lsru_run: begin
               work      <= next_work;
               work_c    <= next_c;
               remaining <= remaining - 8'h01;
               if (last_step) begin
                  state <= lsru_pkg::lsru_idle;
                  busy  <= 1'b0;
               end
            end
            default: begin
               state <= lsru_pkg::lsru_idle;
               busy  <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         result <= `LSRU_RESULT_RST;
      end else if (wr_ctrl) begin
         if (new_op != lsru_pkg::lsru_op_test && (new_logic || new_shift ||
             new_op == lsru_pkg::lsru_op_not)) begin
            result <= lg_val;
         end
      end else if (last_step) begin
         result <= next_work;
      end
   end

   // flags: software may preload them when idle; aux is cleared by logicals
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         carry_flag     <= 1'b0;
         overflow_flag  <= 1'b0;
         aux_carry_flag <= 1'b0;
         sign_flag      <= 1'b0;
         zero_flag      <= 1'b0;
         parity_flag    <= 1'b0;
      end else if (wr_ctrl) begin
         if (new_logic) begin
            carry_flag     <= 1'b0;
            overflow_flag  <= 1'b0;
            aux_carry_flag <= 1'b0;
            sign_flag      <= top_bit(lg_val, new_word);
            zero_flag      <= (lg_val == 16'h0000);
            parity_flag    <= ~^lg_val;
         end
      end else if (last_step) begin
         carry_flag    <= next_c;
         overflow_flag <= orig_msb ^ top_bit(next_work, word);
         if (!run_rot) begin
            sign_flag   <= top_bit(next_work, word);
            zero_flag   <= (next_work == 16'h0000);
            parity_flag <= ~^next_work;
         end
      end else if (bus_wr && idle && wb_sel_i[0] && wb_adr_i == `LSRU_ADR_FLAGS) begin
         carry_flag     <= wb_dat_i[`LSRU_FLG_CARRY];
         overflow_flag  <= wb_dat_i[`LSRU_FLG_OVF];
         aux_carry_flag <= wb_dat_i[`LSRU_FLG_AUX];
         sign_flag      <= wb_dat_i[`LSRU_FLG_SIGN];
         zero_flag      <= wb_dat_i[`LSRU_FLG_ZERO];
         parity_flag    <= wb_dat_i[`LSRU_FLG_PARITY];
      end
   end

   a_logic_clears: assert property (
      @(posedge mclk) disable iff (rst)
      wr_ctrl && new_logic |=> !carry_flag && !overflow_flag)
      else $error("logical op left carry or overflow set");

   a_sign_follows: assert property (
      @(posedge mclk) disable iff (rst)
      wr_ctrl && new_logic |=> sign_flag == top_bit($past(lg_val), $past(new_word)))
      else $error("sign flag does not match result top bit");

   a_zero_follows: assert property (
      @(posedge mclk) disable iff (rst)
      wr_ctrl && new_logic |=> zero_flag == ($past(lg_val) == 16'h0000))
      else $error("zero flag wrong after logical op");

   a_parity_even: assert property (
      @(posedge mclk) disable iff (rst)
      wr_ctrl && new_logic |=> parity_flag == ~^$past(lg_val))
      else $error("parity flag wrong after logical op");

   a_not_keeps: assert property (
      @(posedge mclk) disable iff (rst)
      wr_ctrl && new_op == lsru_pkg::lsru_op_not
      |=> $stable(carry_flag) && $stable(zero_flag) && $stable(sign_flag) &&
          result == (~$past(opa) & $past(new_mask)))
      else $error("invert changed flags or gave wrong value");

   a_and_value: assert property (
      @(posedge mclk) disable iff (rst)
      wr_ctrl && new_op == lsru_pkg::lsru_op_and
      |=> result == ($past(opa) & $past(opb) & $past(new_mask)))
      else $error("and result wrong");

   a_or_value: assert property (
      @(posedge mclk) disable iff (rst)
      wr_ctrl && new_op == lsru_pkg::lsru_op_or
      |=> result == (($past(opa) | $past(opb)) & $past(new_mask)))
      else $error("or result wrong");

   a_xor_value: assert property (
      @(posedge mclk) disable iff (rst)
      wr_ctrl && new_op == lsru_pkg::lsru_op_xor
      |=> result == (($past(opa) ^ $past(opb)) & $past(new_mask)))
      else $error("xor result wrong");

   a_test_nowrite: assert property (
      @(posedge mclk) disable iff (rst)
      wr_ctrl && new_op == lsru_pkg::lsru_op_test |=> $stable(result))
      else $error("test wrote a result");

   a_rotate_keeps: assert property (
      @(posedge mclk) disable iff (rst)
      state == lsru_pkg::lsru_run && run_rot
      |=> $stable(sign_flag) && $stable(zero_flag) && $stable(parity_flag))
      else $error("rotate changed sign, zero or parity");

   a_zero_count: assert property (
      @(posedge mclk) disable iff (rst)
      wr_ctrl && new_shift && new_cnt == 8'h00
      |=> !busy && $stable(carry_flag) && $stable(overflow_flag) && $stable(zero_flag))
      else $error("zero count changed state");

   a_single_done: assert property (
      @(posedge mclk) disable iff (rst)
      wr_ctrl && new_shift && new_cnt == 8'h01 |=> busy ##1 !busy)
      else $error("count of one did not take one step");
endmodule // lsru_top
`default_nettype wire

// File: lsru_map.svh
// register offsets, field positions and constant masks of the shift unit
`ifndef LSRU_MAP_SVH
`define LSRU_MAP_SVH

`define LSRU_ADR_OPA     8'h00
`define LSRU_ADR_OPB     8'h04
`define LSRU_ADR_COUNT   8'h08
`define LSRU_ADR_FLAGS   8'h0c
`define LSRU_ADR_CTRL    8'h10
`define LSRU_ADR_RESULT  8'h14

`define LSRU_FLG_CARRY   0
`define LSRU_FLG_PARITY  1
`define LSRU_FLG_AUX     2
`define LSRU_FLG_ZERO    3
`define LSRU_FLG_SIGN    4
`define LSRU_FLG_OVF     5

`define LSRU_CTL_WORD    4
`define LSRU_CTL_USECNT  5
`define LSRU_CTL_BUSY    8

`define LSRU_MASK_BYTE   16'h00ff
`define LSRU_MASK_WORD   16'hffff
`define LSRU_MSB_BYTE    16'h0080
`define LSRU_MSB_WORD    16'h8000
`define LSRU_COUNT_ONE   8'h01
`define LSRU_RESULT_RST  16'h0000

`endif

// File: lsru_pkg.sv
// types of the logic, shift and rotate unit
`default_nettype none
package lsru_pkg;
   typedef enum logic [3:0] {
      lsru_op_not  = 4'h0,
      lsru_op_and  = 4'h1,
      lsru_op_or   = 4'h2,
      lsru_op_xor  = 4'h3,
      lsru_op_test = 4'h4,
      lsru_op_shift_l  = 4'h5,
      lsru_op_shift_la = 4'h6,
      lsru_op_shift_r  = 4'h7,
      lsru_op_shift_ra = 4'h8,
      lsru_op_rot_l    = 4'h9,
      lsru_op_rot_r    = 4'ha,
      lsru_op_rotc_l   = 4'hb,
      lsru_op_rotc_r   = 4'hc
   } lsru_op_t;

   typedef enum logic [1:0] {
      lsru_idle = 2'b01,
      lsru_run  = 2'b10
   } lsru_state_t;
endpackage
`default_nettype wire

// File: lsru_step.sv
// one-position shift or rotate step at byte or word width
`include "lsru_map.svh"
`default_nettype none
module lsru_step (
   input  wire logic             [15:0] value,      // masked operand
   input  wire logic                    carry_in,   // current carry
   input  wire lsru_pkg::lsru_op_t      op,         // operation
   input  wire logic                    word,       // 1 = 16-bit width
   output logic                  [15:0] next_value, // operand after one step
   output logic                         carry_out   // bit moved out
);
   logic [15:0] msk;
   logic [15:0] top;
   logic [15:0] nv;
   logic        msb;
   logic        lsb;
   logic        co;

   always_comb begin
      msk = word ? `LSRU_MASK_WORD : `LSRU_MASK_BYTE;
      top = word ? `LSRU_MSB_WORD : `LSRU_MSB_BYTE;
      msb = |(value & top);
      lsb = value[0];
      nv  = value;
      co  = carry_in;
      case (op)
         lsru_pkg::lsru_op_shift_l, lsru_pkg::lsru_op_shift_la: begin
            nv = value << 1;
            co = msb;
         end
         lsru_pkg::lsru_op_shift_r: begin
            nv = value >> 1;
            co = lsb;
         end
         lsru_pkg::lsru_op_shift_ra: begin
            nv = (value >> 1) | (msb ? top : 16'h0000);
            co = lsb;
         end
         lsru_pkg::lsru_op_rot_l: begin
            nv = (value << 1) | {15'h0000, msb};
            co = msb;
         end
         lsru_pkg::lsru_op_rot_r: begin
            nv = (value >> 1) | (lsb ? top : 16'h0000);
            co = lsb;
         end
         lsru_pkg::lsru_op_rotc_l: begin
            nv = (value << 1) | {15'h0000, carry_in};
            co = msb;
         end
         lsru_pkg::lsru_op_rotc_r: begin
            nv = (value >> 1) | (carry_in ? top : 16'h0000);
            co = lsb;
         end
         default: begin
            nv = value;
            co = carry_in;
         end
      endcase
      next_value = nv & msk;
      carry_out  = co;
   end
endmodule // lsru_step
`default_nettype wire

// File: lsru_host_model.sv
// wishbone master standing in for the processor decode side
`default_nettype none
module lsru_host_model (
   input  wire logic        mclk,     // clock
   input  wire logic [31:0] wb_dat_o, // read data
   input  wire logic        wb_ack_o, // acknowledge
   output logic             wb_cyc_i, // cycle
   output logic             wb_stb_i, // strobe
   output logic             wb_we_i,  // write enable
   output logic      [7:0]  wb_adr_i, // byte address
   output logic      [3:0]  wb_sel_i, // byte lanes
   output logic      [31:0] wb_dat_i  // write data
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i  = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h00000000;
   end
   // one classic cycle, held until ack is sampled; released lines show inverted junk
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hf;
      wb_dat_i <= d;
      do @(posedge mclk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= ~we;
      wb_adr_i <= ~a;
      wb_dat_i <= ~d;
   endtask
endmodule // lsru_host_model
`default_nettype wire

// File: tb_logic_shift_rotate_unit.sv
// self-checking bench of the logic, shift and rotate unit
`include "lsru_map.svh"
`default_nettype none
module tb_logic_shift_rotate_unit;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        cyc, stb, we;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dat_w, dat_r;
   logic        ack, busy;
   logic [15:0] result, prev;
   logic        c_flg, o_flg, a_flg, s_flg, z_flg, p_flg;
   logic [5:0]  flags;
   logic [8:0]  bcnt;
   int          mismatches = 0;
   int          cmp_count = 0;
   assign flags = {o_flg, s_flg, z_flg, a_flg, p_flg, c_flg};
   always #25 mclk = ~mclk;
   always @(negedge mclk) if (busy === 1'b1) bcnt <= bcnt + 9'h001;

   lsru_top dut_u (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
      .result(result), .carry_flag(c_flg), .overflow_flag(o_flg), .aux_carry_flag(a_flg),
      .sign_flag(s_flg), .zero_flag(z_flg), .parity_flag(p_flg), .busy(busy));
   lsru_host_model host_u (.mclk(mclk), .wb_dat_o(dat_r), .wb_ack_o(ack), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w));

   task automatic cmpv(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmpf(input logic [5:0] got, input logic [5:0] exp, input logic [5:0] m);
      cmp_count++;
      if ((got & m) !== (exp & m)) begin
         mismatches++;
         $display("ERROR t=%0t flags got=%h exp=%h", $time, got & m, exp & m);
      end
   endtask

   function automatic logic [5:0] post(input logic [5:0] f, input logic [15:0] r,
                                       input logic [15:0] t);
      post = {f[5], |(r & t), r == 16'h0000, f[2], ~^r, f[0]};
   endfunction

   // expected {result, flags}; n is the effective count
   function automatic logic [21:0] ref_op(input logic [3:0] op, input logic w,
      input logic [15:0] a, input logic [15:0] b, input logic [7:0] n,
      input logic [5:0] fi, input logic [15:0] pv);
      logic [15:0] m, t, r;
      logic [5:0]  f;
      logic        c;
      m = w ? `LSRU_MASK_WORD : `LSRU_MASK_BYTE;
      t = w ? `LSRU_MSB_WORD : `LSRU_MSB_BYTE;
      r = a & m;
      f = fi;
      if (op == 4'h0) begin
         r = ~a & m;
      end else if (op <= 4'h4) begin
         r = (op == 4'h2) ? (a | b) & m : (op == 4'h3) ? (a ^ b) & m : a & b & m;
         f = post({1'b0, f[4:1], 1'b0}, r, t);
         if (op == 4'h4) r = pv;
      end else if (op > 4'hc) begin
         r = pv;
      end else if (n != 8'h00) begin
         for (int k = 0; k < n; k++) begin
            c = (op == 4'h5 || op == 4'h6 || op == 4'h9 || op == 4'hb) ? |(r & t) : r[0];
            case (op)
               4'h5, 4'h6: r = (r << 1) & m;
               4'h7: r = r >> 1;
               4'h8: r = (r >> 1) | (r & t);
               4'h9: r = ((r << 1) | {15'h0000, c}) & m;
               4'ha: r = (r >> 1) | (c ? t : 16'h0000);
               4'hb: r = ((r << 1) | {15'h0000, f[0]}) & m;
               default: r = (r >> 1) | (f[0] ? t : 16'h0000);
            endcase
            f[0] = c;
         end
         f[5] = |((a ^ r) & t);
         if (op <= 4'h8) f = post(f, r, t);
      end
      ref_op = {r, f};
   endfunction

   task automatic do_op(input logic [3:0] op, input logic w, input logic u,
      input logic [15:0] a, input logic [15:0] b, input logic [7:0] n,
      input logic [5:0] fi, input logic poke);
      logic [21:0] e;
      logic [31:0] q;
      logic [7:0]  k;
      logic [5:0]  m;
      k = u ? n : `LSRU_COUNT_ONE;
      e = ref_op(op, w, a, b, k, fi, prev);
      m = {!(op >= 4'h5 && k > 8'h01), 1'b1, 1'b1, !(op >= 4'h1 && op <= 4'h8), 2'b11};
      host_u.xfer(1'b1, `LSRU_ADR_OPA, {16'h0000, a}, q);
      host_u.xfer(1'b1, `LSRU_ADR_OPB, {16'h0000, b}, q);
      host_u.xfer(1'b1, `LSRU_ADR_COUNT, {24'h000000, n}, q);
      host_u.xfer(1'b1, `LSRU_ADR_FLAGS, {26'h0000000, fi}, q);
      bcnt = 9'h000;
      host_u.xfer(1'b1, `LSRU_ADR_CTRL, {26'h0000000, u, w, op}, q);
      if (poke) host_u.xfer(1'b1, `LSRU_ADR_FLAGS, 32'h0000003f, q);
      @(negedge mclk);
      for (int i = 0; i < 300 && busy !== 1'b0; i++) @(negedge mclk);
      cmpv({31'h00000000, busy}, 32'h00000000);
      cmpv({16'h0000, result}, {16'h0000, e[21:6]});
      cmpf(flags, e[5:0], m);
      cmpv({23'h000000, bcnt}, {24'h000000, (op >= 4'h5 && op <= 4'hc) ? k : 8'h00});
      host_u.xfer(1'b0, `LSRU_ADR_RESULT, 32'h00000000, q);
      cmpv(q, {16'h0000, e[21:6]});
      prev = e[21:6];
   endtask

   task automatic t_bus;
      logic [31:0] q;
      @(negedge mclk);
      cmpv({15'h0000, busy, result}, {16'h0000, `LSRU_RESULT_RST});
      cmpf(flags, 6'h00, 6'h3f);
      host_u.xfer(1'b0, 8'h20, 32'h00000000, q);
      cmpv(q, 32'h00000000);
      host_u.xfer(1'b1, `LSRU_ADR_FLAGS, 32'hffffff2b, q);
      host_u.xfer(1'b0, `LSRU_ADR_FLAGS, 32'h00000000, q);
      cmpv(q, 32'h0000002b);
      $display("test bus done, mismatches %0d", mismatches);
   endtask

   task automatic t_logic;
      for (int w = 0; w < 2; w++) begin
         for (int o = 0; o <= 4; o++) begin
            do_op(o[3:0], w[0], 1'b0, 16'hf0a5, 16'h3c5a, 8'h00, 6'h21, 1'b0);
            do_op(o[3:0], w[0], 1'b0, 16'h80f0, 16'h810f, 8'h00, 6'h3f, 1'b0);
         end
      end
      do_op(4'hd, 1'b0, 1'b0, 16'h1234, 16'h5678, 8'h00, 6'h15, 1'b0);
      $display("test logic done, mismatches %0d", mismatches);
   endtask

   task automatic t_shift;
      for (int w = 0; w < 2; w++) begin
         for (int o = 5; o <= 8; o++) begin
            do_op(o[3:0], w[0], 1'b0, 16'hc0b1, 16'h0000, 8'h07, 6'h00, 1'b0);
            do_op(o[3:0], w[0], 1'b0, 16'h4041, 16'h0000, 8'h07, 6'h01, 1'b0);
            do_op(o[3:0], w[0], 1'b1, 16'h9a53, 16'h0000, 8'h03, 6'h00, 1'b0);
            do_op(o[3:0], w[0], 1'b1, 16'h9a53, 16'h0000, 8'h00, 6'h1b, 1'b0);
         end
      end
      do_op(4'h8, 1'b0, 1'b0, 16'h00fb, 16'h0000, 8'h00, 6'h00, 1'b0);
      cmpv({16'h0000, result}, 32'h000000fd);
      do_op(4'h5, 1'b0, 1'b1, 16'h00ff, 16'h0000, 8'hff, 6'h00, 1'b1);
      $display("test shift done, mismatches %0d", mismatches);
   endtask

   task automatic t_rot;
      for (int w = 0; w < 2; w++) begin
         for (int o = 9; o <= 12; o++) begin
            do_op(o[3:0], w[0], 1'b0, 16'h8421, 16'h0000, 8'h00, 6'h1e, 1'b0);
            do_op(o[3:0], w[0], 1'b1, 16'h8421, 16'h0000, 8'h05, 6'h1f, 1'b0);
            do_op(o[3:0], w[0], 1'b1, 16'h4c02, 16'h0000, 8'h11, 6'h09, 1'b0);
            do_op(o[3:0], w[0], 1'b1, 16'h4c02, 16'h0000, 8'h00, 6'h16, 1'b0);
         end
      end
      $display("test rotate done, mismatches %0d", mismatches);
   endtask

   task automatic print_verdict;
      $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge mclk);
      mismatches++;
      print_verdict();
   end

   initial begin
      prev = 16'h0000;
      bcnt = 9'h000;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      t_bus();
      t_logic();
      t_shift();
      t_rot();
      print_verdict();
   end
endmodule // tb_logic_shift_rotate_unit
`default_nettype wire
